// *** bench/cpw_core_tb.sv ***
/* Self-checking bench for cpw_core with expectations built here.
 Assumes the checker binds itself to the design. */
module cpw_core_tb
	import cpw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, wr, rd, sleep, adc_en, adc_start, flag, pin, oe, line, p;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, v, w;
	logic [31:0] seed;
	int fail_count, n_tests, n, c, hi, ri, pv, d, i, k;
	cpw_mode_t ms[4];
	int pre_c[5], dut_c[5];
	cpw_core dut_u (
		.core_clk_i(clk),
		.rst_b_i(rst_b),
		.reg_addr_i(addr),
		.reg_wdata_i(wdata),
		.reg_wr_i(wr),
		.reg_rd_i(rd),
		.reg_rdata_o(rdata),
		.sleep_i(sleep),
		.adc_enable_i(adc_en),
		.adc_start_o(adc_start),
		.module_event_flag_o(flag),
		.module_output_pin_o(pin),
		.module_output_pin_oe_o(oe)
	);
	cpw_pin_load load_u (.drive_i(oe), .level_i(pin), .line_o(line));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic chk(input string nm, input logic [15:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic end_sim;
		$display("compares %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr_r(input logic [3:0] a, input logic [7:0] dd);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= dd;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_r(input logic [3:0] a, output logic [7:0] dd);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		dd = rdata;
	endtask
	// Bounded wait; a timeout ends the run as a mismatch
	task automatic wait_hi(ref logic s, input int lim, output int cnt);
		cnt = 0;
		while (s !== 1'b1 && cnt < lim) begin
			@(negedge clk);
			cnt++;
		end
		if (s !== 1'b1) begin
			fail_count++;
			$display("BAD wait exp 1 got %b", s);
			end_sim();
		end
	endtask
	initial begin
		ms = '{CPW_M_SET, CPW_M_CLEAR, CPW_M_TOGGLE, CPW_M_SWINT};
		pre_c = '{0, 1, 2, 0, 0};
		dut_c = '{6, 6, 6, 0, 1023};
		{rst_b, wr, rd, sleep, adc_en} = 5'h00;
		addr = 4'h0;
		wdata = 8'h00;
		seed = 32'hBCAC3A0E;
		fail_count = 0;
		n_tests = 0;
		p = 1'b0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		for (i = 0; i < 10; i++)
			if (i != 6 && i != 7) begin
				rd_r(i[3:0], v);
				chk("reset read", v, (i == 3) ? 16'h00FF : 16'h0000);
			end
		$display("reset test done");
		for (i = 0; i < 4; i++) begin
			seed = xs(seed);
			c = 64 + int'(seed[5:0]);
			wr_r(CPW_OFS_T1LO, 8'h00);
			wr_r(CPW_OFS_T1HI, 8'h00);
			wr_r(CPW_OFS_CMP_HI, 8'h00);
			wr_r(CPW_OFS_CMP_LO, c[7:0]);
			wr_r(CPW_OFS_CTRL, {4'h0, ms[i]});
			wait_hi(flag, 300, n);
			repeat (2) @(negedge clk);
			case (ms[i])
				CPW_M_SET: p = 1'b1;
				CPW_M_CLEAR: p = 1'b0;
				CPW_M_TOGGLE: p = ~p;
				default: p = p;
			endcase
			chk("pin", line, (ms[i] != CPW_M_SWINT) & p);
			chk("drive", oe, ms[i] != CPW_M_SWINT);
			wr_r(CPW_OFS_STATUS, 8'h01);
		end
		// The latch was left high by the toggle
		wr_r(CPW_OFS_CTRL, 8'h00);
		wr_r(CPW_OFS_CTRL, {4'h0, CPW_M_TOGGLE});
		repeat (3) @(negedge clk);
		chk("latch", line, 1'b0);
		$display("compare test done");
		@(posedge clk);
		adc_en <= 1'b1;
		seed = xs(seed);
		c = 64 + int'(seed[5:0]);
		wr_r(CPW_OFS_CMP_LO, c[7:0]);
		wr_r(CPW_OFS_T1LO, 8'h00);
		wr_r(CPW_OFS_T1HI, 8'h00);
		wr_r(CPW_OFS_CTRL, {4'h0, CPW_M_SPECIAL});
		wait_hi(adc_start, 300, n);
		@(negedge clk);
		wait_hi(adc_start, 400, n);
		chk("t1 period", 16'(n + 1), 16'(c + 2));
		rd_r(CPW_OFS_STATUS, v);
		chk("status", v, 16'h0001);
		@(posedge clk);
		adc_en <= 1'b0;
		repeat (2 * c + 8) @(negedge clk);
		wr_r(CPW_OFS_CTRL, 8'h00);
		wr_r(CPW_OFS_STATUS, 8'h07);
		$display("special event test done");
		wr_r(CPW_OFS_PERIOD, 8'h03);
		for (i = 0; i < 5; i++) begin
			d = dut_c[i];
			pv = 1 << (2 * pre_c[i]);
			seed = xs(seed);
			wr_r(CPW_OFS_CMP_LO, d[9:2]);
			wr_r(CPW_OFS_CTRL, {2'h0, d[1:0], 4'hC});
			wr_r(CPW_OFS_T2CTRL, {1'b0, seed[3:0], 1'b1, pre_c[i][1:0]});
			// Room for a stale prescaler count to roll over
			repeat (32 * pv + 80) @(negedge clk);
			{hi, ri, p} = {32'h0, 32'h0, line};
			for (k = 0; k < 64 * pv; k++) begin
				@(negedge clk);
				hi += int'(line);
				ri += int'(line & ~p);
				p = line;
			end
			// Registered pin: high from the wrap through the match step
			n = (d == 0) ? 0 : (d >= 16) ? 64 * pv : 4 * (d * pv + 1);
			chk("high time", 16'(hi), 16'(n));
			chk("rises", 16'(ri), (d > 0 && d < 16) ? 16'h0004 : 16'h0000);
			wr_r(CPW_OFS_CMP_HI, 8'h55);
			rd_r(CPW_OFS_CMP_HI, v);
			chk("duty buffer", v, 16'(d >> 2));
		end
		@(posedge clk);
		sleep <= 1'b1;
		repeat (3) @(negedge clk);
		rd_r(CPW_OFS_T2CNT, v);
		repeat (20) @(negedge clk);
		rd_r(CPW_OFS_T2CNT, w);
		chk("sleep count", w, v);
		chk("sleep pin", line, 1'b1);
		@(posedge clk);
		sleep <= 1'b0;
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk("reset drive", oe, 1'b0);
		rd_r(CPW_OFS_PERIOD, v);
		chk("reset period", v, 16'h00FF);
		wr_r(CPW_OFS_CTRL, 8'h0C);
		repeat (3) @(negedge clk);
		chk("pwm drive", oe, 1'b1);
		wr_r(CPW_OFS_CTRL, 8'h00);
		repeat (3) @(negedge clk);
		chk("off drive", oe, 1'b0);
		$display("pwm test done");
		end_sim();
	end
endmodule

// *** bench/cpw_monitor.sv ***
/* Checker on the ports of cpw_core, bound below.
 Assumes one clock and a synchronous active-low reset. */
module cpw_monitor
	import cpw_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// Watched ports
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic sleep_i,
	input wire logic adc_enable_i,
	input wire logic adc_start_o,
	input wire logic module_event_flag_o,
	input wire logic module_output_pin_o,
	input wire logic module_output_pin_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	logic ctl_w;
	assign ctl_w = reg_wr_i && reg_addr_i == CPW_OFS_CTRL;
	AST_ADC_ONE: assert property (adc_start_o |=> !adc_start_o)
		else $error("adc start too long");
	AST_ADC_GATED: assert property (
		$past(!adc_enable_i) && !adc_enable_i |-> !adc_start_o)
		else $error("adc start while disabled");
	AST_RD_IDLE: assert property (
		!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data outside read slot");
	AST_OFF_RELEASE: assert property (ctl_w && reg_wdata_i == 8'h00
		|-> ##2 !module_output_pin_oe_o) else $error("pin kept after off");
	AST_SWINT_FREE: assert property (ctl_w && reg_wdata_i[3:1] == 3'h5
		|-> ##2 !module_output_pin_oe_o) else $error("pin taken in A or B");
	AST_PWM_DRIVE: assert property (ctl_w && reg_wdata_i[3:2] == 2'h3
		|-> ##2 module_output_pin_oe_o) else $error("pwm not driving");
	AST_RESET_STATE: assert property ($rose(rst_b_i)
		|-> !module_output_pin_oe_o && !module_output_pin_o
		&& !module_event_flag_o && !adc_start_o) else $error("reset state");
	AST_SLEEP_HOLD: assert property (sleep_i && $past(sleep_i)
		&& $past(sleep_i, 2) |-> $stable(module_output_pin_o)
		&& $stable(module_output_pin_oe_o)) else $error("pin moved in sleep");
endmodule

bind cpw_core cpw_monitor mon_u (.core_clk_i, .rst_b_i, .reg_addr_i,
	.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sleep_i,
	.adc_enable_i, .adc_start_o, .module_event_flag_o,
	.module_output_pin_o, .module_output_pin_oe_o);

// *** bench/cpw_pin_load.sv ***
/* Load on the output pin with a weak pull-down.
 Assumes the pin direction is set to output outside the unit. */
module cpw_pin_load (
	// From the unit
	input wire logic drive_i,
	input wire logic level_i,
	// Resolved line
	output logic line_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// A released line falls to the pull-down, never keeps the old level
	assign line_o = drive_i ? level_i : 1'b0;
endmodule

// *** core/cpw_core.sv ***
/*
 * Compare and PWM unit with its own Timer1 and Timer2 time bases, reached
 * over a plain register port. Assumes sleep_i and adc_enable_i come from
 * logic on core_clk_i; the port direction latch lives outside this block.
 */
module cpw_core
	import cpw_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// Register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// System
	input wire logic sleep_i,
	input wire logic adc_enable_i,
	output logic adc_start_o,
	output logic module_event_flag_o,
	// Output pin
	output logic module_output_pin_o,
	output logic module_output_pin_oe_o
);

	cpw_req_t req;
	logic [7:0] module_control_reg_q;
	logic [7:0] compare_low_or_duty_upper_q;
	logic [7:0] compare_high_or_duty_buffer_q;
	logic [1:0] duty_low_latch_q;
	logic [7:0] pwm_period_reg_q;
	logic [7:0] timer_two_control_reg_q;
	logic [7:0] timer_two_count_q;
	logic [3:0] pre_cnt_q;
	logic [1:0] phase_q;
	logic [7:0] timer_one_count_low_q;
	logic [7:0] timer_one_count_high_q;
	logic timer_one_overflow_flag_q;
	logic t2_match_flag_q;
	logic cmp_latch_q;
	logic pend_reset_q;
	logic module_event_flag_q;
	logic match_d_q;
	logic adc_start_q;
	cpw_pin_t pin_q;
	logic [7:0] rdata_q;

	logic [3:0] mode;
	logic is_pwm;
	logic is_cmp;
	logic t2_tick;
	logic t2_wrap;
	logic [1:0] base_low;
	logic [9:0] time_base;
	logic [9:0] duty_buf;
	logic [15:0] t1_count;
	logic [15:0] cmp_val;
	logic match;
	logic match_rise;
	logic run;
	logic [3:0] pre_div;
	logic t1_hold;
	logic t1_write;
	logic t1_wrap;
	logic clr_event;
	logic clr_t1ovf;
	logic clr_t2if;

	assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i,
		wdata: reg_wdata_i};
	assign mode = module_control_reg_q[CPW_MODE_LSB +: 4];
	assign is_pwm = (mode[3:2] == 2'h3);
	assign is_cmp = (mode == CPW_M_TOGGLE) || (mode == CPW_M_SET) ||
		(mode == CPW_M_CLEAR) || (mode == CPW_M_SWINT) ||
		(mode == CPW_M_SPECIAL);
	assign run = !sleep_i;

	// Prescale divisor minus one; Timer2 ticks every 4 x prescale clocks
	always_comb begin
		case (timer_two_control_reg_q[CPW_T2_PRE_LSB +: 2])
			CPW_PRE_1: pre_div = 4'h0;
			CPW_PRE_4: pre_div = 4'h3;
			default: pre_div = 4'hF;
		endcase
	end

	assign t2_tick = run && timer_two_control_reg_q[CPW_T2_ON_BIT] &&
		(phase_q == 2'(CPW_PHASES - 1)) && (pre_cnt_q == pre_div);
	// Wrap on the increment after the count equals the period
	assign t2_wrap = t2_tick && (timer_two_count_q == pwm_period_reg_q);

	// Low time-base bits: oscillator phase at 1:1, else prescaler bits
	always_comb begin
		case (timer_two_control_reg_q[CPW_T2_PRE_LSB +: 2])
			CPW_PRE_1: base_low = phase_q;
			CPW_PRE_4: base_low = pre_cnt_q[1:0];
			default: base_low = pre_cnt_q[3:2];
		endcase
	end
	assign time_base = {timer_two_count_q, base_low};
	assign duty_buf = {compare_high_or_duty_buffer_q, duty_low_latch_q};

	assign t1_count = {timer_one_count_high_q, timer_one_count_low_q};
	assign cmp_val = {compare_high_or_duty_buffer_q,
		compare_low_or_duty_upper_q};
	assign match = is_cmp && (t1_count == cmp_val);
	assign match_rise = match && !match_d_q;

	// Special trigger holds Timer1 on the match value for one clock, so
	// the reset edge still sees the match unless software breaks it.
	// Without the hold the count would slip past the compare value
	// before the pending reset could act, and no period would result.
	assign t1_hold = (mode == CPW_M_SPECIAL) && match &&
		!pend_reset_q;

	// Software write to either Timer1 byte
	assign t1_write = req.wr &&
		(req.addr == CPW_OFS_T1LO || req.addr == CPW_OFS_T1HI);

	// Natural rollover only; trigger resets and holds never count
	assign t1_wrap = (t1_count == 16'hFFFF) && !t1_write && !t1_hold &&
		!(pend_reset_q && match);

	// Write-one-to-clear strobes of the status register
	assign clr_event = req.wr && req.addr == CPW_OFS_STATUS &&
		req.wdata[CPW_ST_EVENT_BIT];
	assign clr_t1ovf = req.wr && req.addr == CPW_OFS_STATUS &&
		req.wdata[CPW_ST_T1OVF_BIT];
	assign clr_t2if = req.wr && req.addr == CPW_OFS_STATUS &&
		req.wdata[CPW_ST_T2IF_BIT];

	// Control register; a zero write also clears the compare latch and releases the pin
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			module_control_reg_q <= CPW_CTRL_RST;
		end else if (req.wr && req.addr == CPW_OFS_CTRL) begin
			module_control_reg_q <= req.wdata;
		end
	end

	// Compare low / duty upper bits, writable at any time
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			compare_low_or_duty_upper_q <= 8'h00;
		end else if (req.wr && req.addr == CPW_OFS_CMP_LO) begin
			compare_low_or_duty_upper_q <= req.wdata;
		end
	end

	// Compare high in compare mode, duty buffer in PWM mode
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			compare_high_or_duty_buffer_q <= 8'h00;
			duty_low_latch_q <= 2'h0;
		end else if (is_pwm) begin
			// Software writes are ignored: buffer is read-only here
			if (t2_wrap) begin
				compare_high_or_duty_buffer_q <=
					compare_low_or_duty_upper_q;
				duty_low_latch_q <=
					module_control_reg_q[CPW_DUTY_LO_LSB +: 2];
			end
		end else if (req.wr && req.addr == CPW_OFS_CMP_HI) begin
			compare_high_or_duty_buffer_q <= req.wdata;
		end
	end

	// Period and Timer2 control
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			pwm_period_reg_q <= CPW_PERIOD_RST;
			timer_two_control_reg_q <= CPW_T2CTRL_RST;
		end else if (req.wr && req.addr == CPW_OFS_PERIOD) begin
			pwm_period_reg_q <= req.wdata;
		end else if (req.wr && req.addr == CPW_OFS_T2CTRL) begin
			// Postscaler bits are stored but never reach the time base
			timer_two_control_reg_q <= req.wdata;
		end
	end

	// Oscillator phase and prescaler; all frozen during sleep
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			phase_q <= 2'h0;
			pre_cnt_q <= 4'h0;
		end else if (run && timer_two_control_reg_q[CPW_T2_ON_BIT]) begin
			phase_q <= phase_q + 2'h1;
			if (phase_q == 2'(CPW_PHASES - 1)) begin
				pre_cnt_q <= (pre_cnt_q == pre_div) ? 4'h0 :
					pre_cnt_q + 4'h1;
			end
		end
	end

	// Timer2 count
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			timer_two_count_q <= 8'h00;
			t2_match_flag_q <= 1'b0;
		end else begin
			if (req.wr && req.addr == CPW_OFS_T2CNT) begin
				timer_two_count_q <= req.wdata;
			end else if (t2_wrap) begin
				timer_two_count_q <= 8'h00;
			end else if (t2_tick) begin
				timer_two_count_q <= timer_two_count_q + 8'h01;
			end
			// Set beats a same-cycle clear
			if (t2_wrap) begin
				t2_match_flag_q <= 1'b1;
			end else if (clr_t2if) begin
				t2_match_flag_q <= 1'b0;
			end
		end
	end

	// Timer1 runs one count per system clock outside sleep
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			timer_one_count_low_q <= 8'h00;
			timer_one_count_high_q <= 8'h00;
			timer_one_overflow_flag_q <= 1'b0;
		end else begin
			if (req.wr && req.addr == CPW_OFS_T1LO) begin
				timer_one_count_low_q <= req.wdata;
			end else if (req.wr && req.addr == CPW_OFS_T1HI) begin
				timer_one_count_high_q <= req.wdata;
			end else if (run && pend_reset_q && match) begin
				// Trigger reset; overflow flag untouched
				{timer_one_count_high_q, timer_one_count_low_q} <=
					16'h0000;
			end else if (run && !t1_hold) begin
				{timer_one_count_high_q, timer_one_count_low_q} <=
					t1_count + 16'h0001;
			end
			// Set beats a same-cycle clear
			if (run && t1_wrap) begin
				timer_one_overflow_flag_q <= 1'b1;
			end else if (clr_t1ovf) begin
				timer_one_overflow_flag_q <= 1'b0;
			end
		end
	end

	// Special event trigger and pending Timer1 reset
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			pend_reset_q <= 1'b0;
			match_d_q <= 1'b0;
			adc_start_q <= 1'b0;
		end else begin
			if (run) begin
				match_d_q <= match;
			end
			// Armed on a match while not pending, dropped again on the next clock outside sleep
			pend_reset_q <= run ? (mode == CPW_M_SPECIAL && match &&
				!pend_reset_q) : pend_reset_q;
			adc_start_q <= run && match_rise && mode == CPW_M_SPECIAL &&
				adc_enable_i;
		end
	end

	// Module event flag; set wins over a software clear
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			module_event_flag_q <= 1'b0;
		end else if (run && match_rise) begin
			module_event_flag_q <= 1'b1;
		end else if (clr_event) begin
			module_event_flag_q <= 1'b0;
		end
	end

	// Compare output latch
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			cmp_latch_q <= 1'b0;
		end else if (req.wr && req.addr == CPW_OFS_CTRL &&
			req.wdata == 8'h00) begin
			cmp_latch_q <= 1'b0;
		end else if (run && match_rise) begin
			case (mode)
				CPW_M_TOGGLE: cmp_latch_q <= !cmp_latch_q;
				CPW_M_SET: cmp_latch_q <= 1'b1;
				CPW_M_CLEAR: cmp_latch_q <= 1'b0;
				default: cmp_latch_q <= cmp_latch_q;
			endcase
		end
	end

	// Pin drive; duty above period never matches, so the pin stays set
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i || mode == CPW_M_OFF) begin
			pin_q <= '{drive: 1'b0, level: 1'b0};
		end else if (is_pwm) begin
			pin_q.drive <= 1'b1;
			if (!run) begin
				pin_q.level <= pin_q.level;
			end else if (t2_wrap) begin
				pin_q.level <= ({compare_low_or_duty_upper_q,
					module_control_reg_q[CPW_DUTY_LO_LSB +: 2]} !=
					10'h000);
			end else if (time_base == duty_buf) begin
				pin_q.level <= 1'b0;
			end
		end else begin
			pin_q.drive <= (mode == CPW_M_TOGGLE) || (mode == CPW_M_SET) ||
				(mode == CPW_M_CLEAR);
			pin_q.level <= cmp_latch_q;
		end
	end

	// Read data one cycle after the strobe
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			rdata_q <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				CPW_OFS_CTRL: rdata_q <= module_control_reg_q;
				CPW_OFS_CMP_LO: rdata_q <= compare_low_or_duty_upper_q;
				CPW_OFS_CMP_HI: rdata_q <= compare_high_or_duty_buffer_q;
				CPW_OFS_PERIOD: rdata_q <= pwm_period_reg_q;
				CPW_OFS_T2CTRL: rdata_q <= timer_two_control_reg_q;
				CPW_OFS_T2CNT: rdata_q <= timer_two_count_q;
				CPW_OFS_T1LO: rdata_q <= timer_one_count_low_q;
				CPW_OFS_T1HI: rdata_q <= timer_one_count_high_q;
				CPW_OFS_STATUS: rdata_q <= {5'h00, t2_match_flag_q,
					timer_one_overflow_flag_q, module_event_flag_q};
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign adc_start_o = adc_start_q;
	assign module_event_flag_o = module_event_flag_q;
	assign module_output_pin_o = pin_q.level;
	assign module_output_pin_oe_o = pin_q.drive;

endmodule

// *** core/cpw_pkg.sv ***
/*
 * Package for the compare and PWM unit: register offsets, field positions,
 * mode encodings, reset values and the packed carriers shared by the core.
 * Assumes a single 20 MHz system clock and a plain register port.
 */
package cpw_pkg;

	// Register offsets on the plain register port
	localparam logic [3:0] CPW_OFS_CTRL = 4'h0;
	localparam logic [3:0] CPW_OFS_CMP_LO = 4'h1;
	localparam logic [3:0] CPW_OFS_CMP_HI = 4'h2;
	localparam logic [3:0] CPW_OFS_PERIOD = 4'h3;
	localparam logic [3:0] CPW_OFS_T2CTRL = 4'h4;
	localparam logic [3:0] CPW_OFS_T2CNT = 4'h5;
	localparam logic [3:0] CPW_OFS_T1LO = 4'h6;
	localparam logic [3:0] CPW_OFS_T1HI = 4'h7;
	localparam logic [3:0] CPW_OFS_STATUS = 4'h8;

	// Control register fields
	localparam int CPW_MODE_LSB = 0;
	localparam int CPW_DUTY_LO_LSB = 4;
	// Timer2 control fields
	localparam int CPW_T2_PRE_LSB = 0;
	localparam int CPW_T2_ON_BIT = 2;
	localparam int CPW_T2_POST_LSB = 3;
	// Status fields
	localparam int CPW_ST_EVENT_BIT = 0;
	localparam int CPW_ST_T1OVF_BIT = 1;
	localparam int CPW_ST_T2IF_BIT = 2;

	localparam logic [7:0] CPW_CTRL_RST = 8'h00;
	localparam logic [7:0] CPW_PERIOD_RST = 8'hFF;
	localparam logic [7:0] CPW_T2CTRL_RST = 8'h00;

	// Oscillator cycles per Timer2 input tick at prescale 1:1
	localparam int CPW_PHASES = 4;

	typedef enum logic [3:0] {
		CPW_M_OFF = 4'h0,
		CPW_M_TOGGLE = 4'h2,
		CPW_M_SET = 4'h8,
		CPW_M_CLEAR = 4'h9,
		CPW_M_SWINT = 4'hA,
		CPW_M_SPECIAL = 4'hB
	} cpw_mode_t;

	typedef enum logic [1:0] {
		CPW_PRE_1 = 2'h0,
		CPW_PRE_4 = 2'h1,
		CPW_PRE_16 = 2'h2
	} cpw_pre_t;

	// Register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} cpw_req_t;

	// Pin drive bundle
	typedef struct packed {
		logic drive;
		logic level;
	} cpw_pin_t;

endpackage
